// file: pkg/fsrf_pkg.sv
// Constants and types shared by the full-status readback responder.
package fsrf_pkg;

  // Preparing frame decode.
  localparam logic [6:0] QUERY_CMD_CODE  = 7'h01;
  localparam logic [7:0] APP_CMD_CODE    = 8'h80;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL_OFS    = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS  = 8'h04;
  localparam logic [7:0] REG_MASK_OFS    = 8'h08;
  localparam logic [7:0] REG_STATE_OFS   = 8'h0C;

  // Values after reset.
  localparam logic       CTRL_RESET      = 1'b1;
  localparam logic [3:0] MASK_RESET      = 4'h0;
  localparam logic [3:0] STATUS_RESET    = 4'h0;

  // Event bit positions, shared by the status and mask registers.
  localparam int         EV_ACCEPT       = 0;
  localparam int         EV_FIRST        = 1;
  localparam int         EV_SECOND       = 2;
  localparam int         EV_IGNORED      = 3;
  localparam int         EV_WIDTH        = 4;

  typedef enum logic [2:0] {
    FSRF_IDLE   = 3'b001,
    FSRF_ARMED  = 3'b010,
    FSRF_SECOND = 3'b100
  } fsrf_state_t;

endpackage

// file: tb/fsrf_master_model.sv
// Bus master model that issues decoded preparing and reading frames.
`timescale 1ns/1ps
`default_nettype none

module fsrf_master_model (
  // Clock
  input  wire logic       clk_in,
  // Decoded frames
  output logic            prep_valid_out,
  output logic            prep_ext_out,
  output logic [7:0]      app_byte_out,
  output logic [6:0]      prep_cmd_out,
  output logic [6:0]      prep_addr_out,
  output logic            read_req_out
);
  initial begin
    prep_valid_out = 1'b0;
    prep_ext_out = 1'b0;
    app_byte_out = 8'h00;
    prep_cmd_out = 7'h00;
    prep_addr_out = 7'h00;
    read_req_out = 1'b0;
  end

  // Fields are only valid with the pulse, so they are inverted after it.
  task automatic prep(input logic ext, input logic [7:0] app, input logic [6:0] cmd,
                      input logic [6:0] adr);
    @(posedge clk_in);
    prep_valid_out <= 1'b1;
    prep_ext_out <= ext;
    app_byte_out <= app;
    prep_cmd_out <= cmd;
    prep_addr_out <= adr;
    @(posedge clk_in);
    prep_valid_out <= 1'b0;
    prep_ext_out <= ~ext;
    app_byte_out <= ~app;
    prep_cmd_out <= ~cmd;
    prep_addr_out <= ~adr;
  endtask

  // A reading frame, sent promptly or after some idle cycles.
  task automatic rd(input int gap);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    read_req_out <= 1'b1;
    @(posedge clk_in);
    read_req_out <= 1'b0;
  endtask
endmodule

`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench of the full-status responder against a queue model.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk_in, sys_rst_in, reg_wr_in, reg_rd_in, irq_out, en;
  logic [7:0]  reg_addr_in, app;
  logic [31:0] reg_wdata_in, reg_rdata_out, seed, w;
  logic        prep_valid, prep_ext, read_req;
  logic [6:0]  cmd, padr, node;
  logic        resp_valid_out, resp_second_out, clear_flags_out;
  logic [63:0] resp_data_out, f1, f2, m1, m2;
  logic [10:0] sec, msec;
  logic [64:0] s2;
  logic [64:0] exp_q[$];
  int          errors, total_checks, st, stat, mask, i, c;

  fsrf_master_model u_fsrf_master_model (.clk_in, .prep_valid_out(prep_valid),
    .prep_ext_out(prep_ext), .app_byte_out(app), .prep_cmd_out(cmd),
    .prep_addr_out(padr), .read_req_out(read_req));

  fsrf_status_responder u_fsrf_status_responder (.clk_in, .sys_rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out,
    .prep_valid_in(prep_valid), .prep_ext_in(prep_ext), .application_command_byte_in(app),
    .prep_cmd_in(cmd), .prep_addr_in(padr), .read_req_in(read_req), .node_addr_in(node),
    .resp_valid_out, .resp_second_out, .resp_data_out, .clear_flags_out,
    .run_current_in(f1[55:52]), .hold_current_in(f1[51:48]), .max_velocity_in(f1[47:44]),
    .min_velocity_in(f1[43:40]), .accel_shape_in(f1[39]), .step_mode_in(f1[38:37]),
    .shaft_dir_in(f1[36]), .acceleration_in(f1[35:32]), .supply_reset_flag_in(f1[31]),
    .step_loss_flag_in(f1[30]), .electrical_defect_flag_in(f1[29]),
    .undervoltage_flag_in(f1[28]), .thermal_shutdown_flag_in(f1[27]),
    .thermal_warning_flag_in(f1[26]), .temp_info_in(f1[25:24]),
    .motion_state_in(f1[23:21]), .ext_switch_in(f1[20]), .overcurrent_coil_x_flag_in(f1[19]),
    .overcurrent_coil_y_flag_in(f1[18]), .stall_flag_in(f1[17]), .pwm_freq_sel_in(f1[15]),
    .boost_disable_in(f1[14]), .stab_time_in(f1[13:12]), .link_timeout_err_in(f1[11]),
    .link_data_err_in(f1[10]), .link_header_err_in(f1[9]), .link_bit_err_in(f1[8]),
    .absolute_stall_threshold_in(f1[7:4]), .second_undervoltage_flag_in(f1[3]),
    .third_undervoltage_threshold_in(f1[2:0]), .actual_position_in(f2[55:40]),
    .target_position_in(f2[39:24]), .secure_position_in(sec),
    .full_step_stall_enable_in(f2[15:13]), .full_duty_flag_in(f2[11]),
    .absolute_stall_flag_in(f2[7]), .minimum_sample_count_in(f2[4:2]),
    .full_duty_stall_enable_in(f2[1]), .pwm_jitter_enable_in(f2[0]));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [63:0] e1();
    return {1'b1, node, m1[55:17], 1'b0, m1[15:0]};
  endfunction

  function automatic logic [63:0] e2();
    return {1'b1, node, m2[55:24], msec[7:0], m2[15:13], 1'b1, m2[11], msec[10:8], m2[7],
            2'b00, m2[4:0]};
  endfunction

  task automatic chk(input string nm, input logic [64:0] e, input logic [64:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic rnd();
    @(posedge clk_in);
    m1 = {xs(), xs()};
    m2 = {xs(), xs()};
    w = xs();
    msec = w[10:0];
    f1 <= m1;
    f2 <= m2;
    sec <= msec;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk("register read", 65'(e), 65'(reg_rdata_out));
  endtask

  task automatic prep(input logic x, input logic [7:0] a, input logic [6:0] k, input logic [6:0] d);
    u_fsrf_master_model.prep(x, a, k, d);
    if (en && k == fsrf_pkg::QUERY_CMD_CODE && d == node &&
        (!x || a == fsrf_pkg::APP_CMD_CODE)) begin
      st = 1;
      stat |= 1;
    end else st = 0;
  endtask

  task automatic rdf(input int gap);
    if (st == 1) begin
      exp_q.push_back({1'b0, e1()});
      s2 = {1'b1, e2()};
      st = 2;
      stat |= 2;
    end else if (st == 2) begin
      exp_q.push_back(s2);
      st = 0;
      stat |= 4;
    end else stat |= 8;
    u_fsrf_master_model.rd(gap);
  endtask

  always @(negedge clk_in) begin
    if (!sys_rst_in) begin
      chk("clear request", 65'(resp_valid_out & ~resp_second_out), 65'(clear_flags_out));
      if (resp_valid_out !== 1'b0) begin
        if (exp_q.size() == 0) chk("unexpected response", 65'(0), 65'(1));
        else chk("response", exp_q.pop_front(), {resp_second_out, resp_data_out});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    results();
  end

  initial begin
    seed = 32'h840c_ddf3;
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    {f1, f2, sec, m1, m2, msec} = '0;
    w = xs();
    node = w[6:0];
    {errors, total_checks, st, stat, mask} = '0;
    en = 1'b1;
    sys_rst_in = 1'b1;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rdr(fsrf_pkg::REG_CTRL_OFS, 32'h0000_0001);
    rdr(fsrf_pkg::REG_MASK_OFS, 32'h0000_0000);
    rdr(fsrf_pkg::REG_STATE_OFS, 32'h0000_0001);
    rdr(8'h10, 32'h0000_0000);
    for (i = 0; i < 16; i++) begin
      c = i % 8;
      w = xs();
      mask = int'(w[3:0]);
      wr(fsrf_pkg::REG_MASK_OFS, {28'h000_0000, w[3:0]});
      en = (c != 7);
      wr(fsrf_pkg::REG_CTRL_OFS, {31'h0000_0000, en});
      rnd();
      prep(c[0], (c == 5) ? 8'h81 : 8'h80, (c == 2) ? 7'h02 : 7'h01,
           (c == 3) ? (node ^ 7'h01) : node);
      rdf(c);
      rnd();
      if (c != 0) rdf(0);
      rdr(fsrf_pkg::REG_STATE_OFS, 32'(1 << st));
      chk("interrupt", 65'(|(stat & mask)), 65'(irq_out));
      rdr(fsrf_pkg::REG_STATUS_OFS, 32'(stat));
      stat = 0;
    end
    repeat (4) @(posedge clk_in);
    chk("responses left", 65'(0), 65'(exp_q.size()));
    results();
  end
endmodule

`default_nettype wire

// file: verilog/fsrf_regs.sv
// Register slave with sticky event status, mask and interrupt output.
`timescale 1ns/1ps
`default_nettype none

module fsrf_regs (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // Block side
  input  wire logic [3:0]  events_in,
  input  wire logic [2:0]  phase_in,
  output logic             enable_out,
  output logic             irq_out
);

  logic        ctrl_q;
  logic        ctrl_d;
  logic [3:0]  mask_q;
  logic [3:0]  mask_d;
  logic [3:0]  stat_q;
  logic [3:0]  stat_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_comb begin
    ctrl_d  = ctrl_q;
    mask_d  = mask_q;
    rdata_d = 32'h0000_0000;
    stat_d  = stat_q;
    if (reg_wr_in && reg_addr_in == fsrf_pkg::REG_CTRL_OFS) begin
      ctrl_d = reg_wdata_in[0];
    end
    if (reg_wr_in && reg_addr_in == fsrf_pkg::REG_MASK_OFS) begin
      mask_d = reg_wdata_in[3:0];
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        fsrf_pkg::REG_CTRL_OFS: begin
          rdata_d = {31'h0000_0000, ctrl_q};
        end
        fsrf_pkg::REG_STATUS_OFS: begin
          rdata_d = {28'h000_0000, stat_q};
          stat_d  = 4'h0;
        end
        fsrf_pkg::REG_MASK_OFS: begin
          rdata_d = {28'h000_0000, mask_q};
        end
        fsrf_pkg::REG_STATE_OFS: begin
          rdata_d = {29'h000_0000, phase_in};
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
    // An event in the same cycle as the clearing read is kept.
    stat_d = stat_d | events_in;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_q  <= fsrf_pkg::CTRL_RESET;
      mask_q  <= fsrf_pkg::MASK_RESET;
      stat_q  <= fsrf_pkg::STATUS_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q  <= ctrl_d;
      mask_q  <= mask_d;
      stat_q  <= stat_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign enable_out    = ctrl_q;
  assign irq_out       = |(stat_q & mask_q);

endmodule

`default_nettype wire

// file: verilog/fsrf_status_responder.sv
// Full-status query responder: accepts the preparing frame, answers two reading frames.
//
// Overview of operation
// - A type 6 reading frame after an accepted status preparing frame is answered with the data bytes.
// - The first response carries run current in the upper and hold current in the lower nibble of byte 2.
// - Byte 8 of the first response is stall threshold, second undervoltage flag, then the 3-bit threshold.
// - Byte 7 of the second response is stall enable, a one, full-duty flag, secure position bits 10 to 8.
// - Byte 8 of the second response is stall flag, two zeros, sample count, duty stall and jitter enables.
// - Serving the query pulses a request to clear the latched fault flags after they are reported.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module fsrf_status_responder (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  output logic             irq_out,
  // Decoded frames from the link layer
  input  wire logic        prep_valid_in,
  input  wire logic        prep_ext_in,
  input  wire logic [7:0]  application_command_byte_in,
  input  wire logic [6:0]  prep_cmd_in,
  input  wire logic [6:0]  prep_addr_in,
  input  wire logic        read_req_in,
  input  wire logic [6:0]  node_addr_in,
  // Responses
  output logic             resp_valid_out,
  output logic             resp_second_out,
  output logic      [63:0] resp_data_out,
  output logic             clear_flags_out,
  // Settings and state, first response
  input  wire logic [3:0]  run_current_in,
  input  wire logic [3:0]  hold_current_in,
  input  wire logic [3:0]  max_velocity_in,
  input  wire logic [3:0]  min_velocity_in,
  input  wire logic        accel_shape_in,
  input  wire logic [1:0]  step_mode_in,
  input  wire logic        shaft_dir_in,
  input  wire logic [3:0]  acceleration_in,
  input  wire logic        supply_reset_flag_in,
  input  wire logic        step_loss_flag_in,
  input  wire logic        electrical_defect_flag_in,
  input  wire logic        undervoltage_flag_in,
  input  wire logic        thermal_shutdown_flag_in,
  input  wire logic        thermal_warning_flag_in,
  input  wire logic [1:0]  temp_info_in,
  input  wire logic [2:0]  motion_state_in,
  input  wire logic        ext_switch_in,
  input  wire logic        overcurrent_coil_x_flag_in,
  input  wire logic        overcurrent_coil_y_flag_in,
  input  wire logic        stall_flag_in,
  input  wire logic        pwm_freq_sel_in,
  input  wire logic        boost_disable_in,
  input  wire logic [1:0]  stab_time_in,
  input  wire logic        link_timeout_err_in,
  input  wire logic        link_data_err_in,
  input  wire logic        link_header_err_in,
  input  wire logic        link_bit_err_in,
  input  wire logic [3:0]  absolute_stall_threshold_in,
  input  wire logic        second_undervoltage_flag_in,
  input  wire logic [2:0]  third_undervoltage_threshold_in,
  // Positions and stall settings, second response
  input  wire logic [15:0] actual_position_in,
  input  wire logic [15:0] target_position_in,
  input  wire logic [10:0] secure_position_in,
  input  wire logic [2:0]  full_step_stall_enable_in,
  input  wire logic        full_duty_flag_in,
  input  wire logic        absolute_stall_flag_in,
  input  wire logic [2:0]  minimum_sample_count_in,
  input  wire logic        full_duty_stall_enable_in,
  input  wire logic        pwm_jitter_enable_in
);

  fsrf_pkg::fsrf_state_t state_q;
  fsrf_pkg::fsrf_state_t state_d;
  logic [63:0] data_q;
  logic [63:0] data_d;
  logic [63:0] snap_q;
  logic [63:0] snap_d;
  logic        valid_q;
  logic        valid_d;
  logic        second_q;
  logic        second_d;
  logic        clear_q;
  logic        clear_d;
  logic [3:0]  events;
  logic        enable;
  logic        query_ok;
  logic [63:0] pack_first;
  logic [63:0] pack_second;

  // Type 8 frames must also carry the application command byte.
  assign query_ok = enable && prep_cmd_in == fsrf_pkg::QUERY_CMD_CODE
                    && prep_addr_in == node_addr_in
                    && (!prep_ext_in
                        || application_command_byte_in == fsrf_pkg::APP_CMD_CODE);

  assign pack_first = {
    1'b1, node_addr_in,
    run_current_in, hold_current_in,
    max_velocity_in, min_velocity_in,
    accel_shape_in, step_mode_in, shaft_dir_in, acceleration_in,
    supply_reset_flag_in, step_loss_flag_in, electrical_defect_flag_in,
    undervoltage_flag_in, thermal_shutdown_flag_in, thermal_warning_flag_in, temp_info_in,
    motion_state_in, ext_switch_in, overcurrent_coil_x_flag_in,
    overcurrent_coil_y_flag_in, stall_flag_in, 1'b0,
    pwm_freq_sel_in, boost_disable_in, stab_time_in,
    link_timeout_err_in, link_data_err_in, link_header_err_in, link_bit_err_in,
    absolute_stall_threshold_in, second_undervoltage_flag_in,
    third_undervoltage_threshold_in
  };

  assign pack_second = {
    1'b1, node_addr_in,
    actual_position_in,
    target_position_in,
    secure_position_in[7:0],
    full_step_stall_enable_in, 1'b1, full_duty_flag_in, secure_position_in[10:8],
    absolute_stall_flag_in, 2'b00, minimum_sample_count_in,
    full_duty_stall_enable_in, pwm_jitter_enable_in
  };

  always_comb begin
    state_d  = state_q;
    data_d   = data_q;
    snap_d   = snap_q;
    valid_d  = 1'b0;
    second_d = 1'b0;
    clear_d  = 1'b0;
    events   = 4'h0;
    if (prep_valid_in) begin
      // Any other preparing frame drops a pending query.
      if (query_ok) begin
        state_d                    = fsrf_pkg::FSRF_ARMED;
        events[fsrf_pkg::EV_ACCEPT] = 1'b1;
      end else begin
        state_d = fsrf_pkg::FSRF_IDLE;
      end
    end else if (read_req_in) begin
      case (state_q)
        fsrf_pkg::FSRF_ARMED: begin
          valid_d                    = 1'b1;
          data_d                     = pack_first;
          snap_d                     = pack_second;
          clear_d                    = 1'b1;
          state_d                    = fsrf_pkg::FSRF_SECOND;
          events[fsrf_pkg::EV_FIRST] = 1'b1;
        end
        fsrf_pkg::FSRF_SECOND: begin
          valid_d                     = 1'b1;
          second_d                    = 1'b1;
          data_d                      = snap_q;
          state_d                     = fsrf_pkg::FSRF_IDLE;
          events[fsrf_pkg::EV_SECOND] = 1'b1;
        end
        fsrf_pkg::FSRF_IDLE: begin
          events[fsrf_pkg::EV_IGNORED] = 1'b1;
        end
        default: begin
          state_d = fsrf_pkg::FSRF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q  <= fsrf_pkg::FSRF_IDLE;
      data_q   <= 64'h0000_0000_0000_0000;
      snap_q   <= 64'h0000_0000_0000_0000;
      valid_q  <= 1'b0;
      second_q <= 1'b0;
      clear_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      data_q   <= data_d;
      snap_q   <= snap_d;
      valid_q  <= valid_d;
      second_q <= second_d;
      clear_q  <= clear_d;
    end
  end

  assign resp_valid_out  = valid_q;
  assign resp_second_out = second_q;
  assign resp_data_out   = data_q;
  assign clear_flags_out = clear_q;

  fsrf_regs u_regs (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_wr_in     (reg_wr_in),
    .reg_rd_in     (reg_rd_in),
    .reg_rdata_out (reg_rdata_out),
    .events_in     (events),
    .phase_in      (state_q),
    .enable_out    (enable),
    .irq_out       (irq_out)
  );

  // Values seen when the first response was built, for checking the second.
  logic [31:0] chk_q;
  always_ff @(posedge clk_in) begin
    if (events[fsrf_pkg::EV_FIRST]) begin
      chk_q <= {actual_position_in, full_step_stall_enable_in, full_duty_flag_in,
                secure_position_in, absolute_stall_flag_in};
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_first_read_answer:
    assert property (state_q == fsrf_pkg::FSRF_ARMED && read_req_in && !prep_valid_in
                     |=> resp_valid_out && !resp_second_out
                         && resp_data_out[63:56] == {1'b1, $past(node_addr_in)})
    else $error("First reading frame not answered.");

  a_second_read_answer:
    assert property (state_q == fsrf_pkg::FSRF_SECOND && read_req_in && !prep_valid_in
                     |=> resp_valid_out && resp_second_out)
    else $error("Second reading frame not answered.");

  a_current_nibbles:
    assert property (resp_valid_out && !resp_second_out
                     |-> resp_data_out[55:48] == {$past(run_current_in), $past(hold_current_in)})
    else $error("Current nibbles misplaced in first response.");

  a_first_last_byte:
    assert property (resp_valid_out && !resp_second_out
                     |-> resp_data_out[7:0] == {$past(absolute_stall_threshold_in),
                         $past(second_undervoltage_flag_in),
                         $past(third_undervoltage_threshold_in)})
    else $error("Byte 8 of first response wrong.");

  a_second_byte_seven:
    assert property (resp_valid_out && resp_second_out
                     |-> resp_data_out[15:8] == {chk_q[15:13], 1'b1, chk_q[12], chk_q[11:9]}
                         && resp_data_out[12])
    else $error("Byte 7 of second response wrong.");

  a_second_byte_eight:
    assert property (resp_valid_out && resp_second_out
                     |-> resp_data_out[7] == chk_q[0] && resp_data_out[6:5] == 2'b00)
    else $error("Byte 8 of second response wrong.");

  a_snapshot_position:
    assert property (resp_valid_out && resp_second_out
                     |-> resp_data_out[55:40] == chk_q[31:16]
                         && resp_data_out[23:16] == chk_q[8:1])
    else $error("Second response does not match the snapshot instant.");

  a_flag_clear_pulse:
    assert property (clear_flags_out == (resp_valid_out && !resp_second_out))
    else $error("Flag clear not tied to the first response.");

  c_both_responses:
    cover property (resp_valid_out && !resp_second_out ##[1:1000]
                    resp_valid_out && resp_second_out);
  c_second_skipped:
    cover property (state_q == fsrf_pkg::FSRF_SECOND && prep_valid_in && query_ok);
  c_read_ignored:
    cover property (state_q == fsrf_pkg::FSRF_IDLE && read_req_in && !prep_valid_in);

endmodule

`default_nettype wire
